// *** verilog/panel_pkg.sv ***
package panel_pkg;
  // timing: clock in MHz, enable tick in microseconds, delays in milliseconds of the enable tick
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int DEB_MS = 10;
  localparam int RPT_DELAY_MS = 500;
  localparam int RPT_RATE_MS = 100;
  localparam int FLASH_MS = 250;
  // keys
  localparam int NKEY = 5;
  localparam int K_ESC = 0;
  localparam int K_UP = 1;
  localparam int K_DN = 2;
  localparam int K_SH = 3;
  localparam int K_SET = 4;
  localparam logic [4:0] RPT_KEYS = 5'h06;
  // menu
  localparam logic [2:0] GRP_SYS = 3'h0;
  localparam logic [2:0] GRP_MON = 3'h2;
  localparam logic [4:0] NUM_UNLOCK = 5'h00;
  localparam logic [4:0] NUM_INIT = 5'h10;
  localparam logic [7:0] IMM_GROUPS = 8'hFA;
  localparam logic [7:0] IDX_LAST = 8'hFF;
  localparam logic [2:0] FPOS_LAST = 3'h4;
  localparam logic [16:0] UNLOCK_VAL = 17'h00164;
  localparam logic [16:0] INIT_RESTORE = 17'h00001;
  localparam logic [16:0] INIT_SAVE = 17'h00002;
  localparam logic [16:0] VAL_MAX = 17'h1869F;
  localparam logic [16:0] DEF_VAL = 17'h00000;
  // monitor items
  localparam logic [4:0] MN_SPEED = 5'h00;
  localparam logic [4:0] MN_MODE = 5'h01;
  localparam logic [4:0] MN_VER = 5'h03;
  localparam logic [4:0] MN_POS_LO = 5'h04;
  localparam logic [4:0] MN_POS_HI = 5'h05;
  localparam logic [4:0] MN_CMD_LO = 5'h06;
  localparam logic [4:0] MN_CMD_HI = 5'h07;
  localparam logic [4:0] MN_TORQUE = 5'h0A;
  localparam logic [4:0] MN_IN_HI = 5'h0C;
  localparam logic [4:0] MN_IN_LO = 5'h0D;
  localparam logic [4:0] MN_OUT = 5'h0E;
  localparam logic [4:0] MN_FREQ = 5'h0F;
  localparam logic [4:0] MN_FAULT = 5'h13;
  localparam logic [4:0] MN_ROTOR = 5'h14;
  localparam logic [4:0] MN_MODEL = 5'h19;
  localparam logic [31:0] POS_LIM = 32'h3B9AC9FF;
  localparam logic [31:0] POS_SPLIT = 32'h00002710;
  localparam logic [15:0] ROT_CYCLE = 16'h2710;
  // register offsets
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_STAT = 8'h04;
  localparam logic [7:0] WB_PADDR = 8'h08;
  localparam logic [7:0] WB_PDATA = 8'h0C;
  // display characters
  typedef logic [4:0] ch_t;
  typedef ch_t [4:0] dig5_t;
  localparam ch_t CH_0 = 5'h00;
  localparam ch_t CH_1 = 5'h01;
  localparam ch_t CH_MINUS = 5'h0A;
  localparam ch_t CH_BLANK = 5'h0B;
  localparam ch_t CH_E = 5'h0C;
  localparam ch_t CH_R = 5'h0D;
  localparam ch_t CH_V = 5'h0E;
  localparam ch_t CH_S = 5'h0F;
  localparam ch_t CH_T = 5'h10;
  localparam ch_t CH_A = 5'h11;
  localparam ch_t CH_D = 5'h12;
  localparam ch_t CH_O = 5'h13;
  localparam ch_t CH_N = 5'h14;
  localparam ch_t CH_P = 5'h15;
  localparam dig5_t MSG_START = {CH_S, CH_T, CH_A, CH_R, CH_T};
  localparam dig5_t MSG_DONE = {CH_D, CH_O, CH_N, CH_E, CH_BLANK};
  typedef enum logic [2:0] {M_POS, M_ASPD, M_TRQ, M_ISPD, M_SPD_TRY, M_JOG_TRY, M_FACT} mode_t;
  typedef struct packed {
    dig5_t ch;
    logic [4:0] dot;
  } disp_t;
  typedef struct packed {
    logic signed [15:0] speed;
    mode_t mode;
    logic model_e;
    logic [6:0] model_num;
    logic [9:0] version;
    logic signed [31:0] pos_fb;
    logic signed [31:0] pos_cmd;
    logic signed [15:0] torque;
    logic [6:0] din_cur;
    logic [3:0] dout_on;
    logic signed [15:0] freq;
    logic fault_act;
    logic [7:0] fault_code;
    logic [15:0] rotor;
  } mon_t;

  // five decimal digits, units in slot 0
  function automatic dig5_t dec5(input logic [16:0] v);
    logic [16:0] r;
    r = v;
    dec5 = '0;
    for (int i = 0; i < 5; i++)
    begin
      dec5[i] = ch_t'(r % 17'h0000A);
      r = r / 17'h0000A;
    end
  endfunction : dec5
endpackage : panel_pkg

// *** verilog/key_cond.sv ***
module key_cond #(
  parameter int N = panel_pkg::NKEY,
  parameter int DEB = panel_pkg::DEB_MS,
  parameter int RDLY = panel_pkg::RPT_DELAY_MS,
  parameter int RRATE = panel_pkg::RPT_RATE_MS,
  parameter logic [N-1:0] RPT = panel_pkg::RPT_KEYS
) (
  // clock, reset, tick
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  // keys in, actions out
  input wire logic [N-1:0] key_i,
  output logic [N-1:0] press_o
);
  if (DEB < 1 || DEB > 255 || RDLY < 1 || RDLY > 1023 || RRATE < 1 || RRATE > 1023)
    $error("key_cond: timing out of range");

  typedef struct packed {
    logic [N-1:0] stab;
    logic [N-1:0] press;
    logic [N-1:0][7:0] dcnt;
    logic [N-1:0][9:0] rcnt;
  } st_t;
  st_t s;
  st_t n;

  // debounce, press edge and hold repeat per key
  always_comb
  begin
    n = s;
    n.press = '0;
    for (int i = 0; i < N; i++)
    begin
      if (key_i[i] == s.stab[i])
        n.dcnt[i] = '0;
      else if (tick_i)
      begin
        n.dcnt[i] = s.dcnt[i] + 8'h01;
        if (s.dcnt[i] == 8'(DEB - 1))
        begin
          n.dcnt[i] = '0;
          n.stab[i] = key_i[i];
          n.press[i] = key_i[i];
          n.rcnt[i] = 10'(RDLY - 1);
        end
      end
      if (s.stab[i] && RPT[i] && tick_i)
      begin
        n.rcnt[i] = s.rcnt[i] - 10'h001;
        if (s.rcnt[i] == '0)
        begin
          n.press[i] = 1'b1;
          n.rcnt[i] = 10'(RRATE - 1);
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= n;
  end

  assign press_o = s.press;
endmodule : key_cond

// *** verilog/mon_fmt.sv ***
module mon_fmt (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // selected item and drive values
  input wire logic [4:0] num_i,
  input wire panel_pkg::mon_t mon_i,
  // formatted digits
  output panel_pkg::disp_t disp_o
);
  typedef struct packed {
    panel_pkg::disp_t disp;
  } st_t;
  st_t s;
  st_t n;
  logic [31:0] pv;
  logic [31:0] pm;
  logic [15:0] sv;
  logic neg;
  logic [16:0] mag;

  // pick the quantity, then lay out the digits
  always_comb
  begin
    n = s;
    pv = num_i[1] ? mon_i.pos_cmd : mon_i.pos_fb; // gear-scaled upstream
    pm = pv[31] ? 32'h0 - pv : pv;
    if (pm > panel_pkg::POS_LIM)
      pm = panel_pkg::POS_LIM;
    sv = mon_i.speed;
    if (num_i == panel_pkg::MN_TORQUE)
      sv = mon_i.torque; // percent of rated
    if (num_i == panel_pkg::MN_FREQ)
      sv = mon_i.freq; // 0.1 kHz, signed by direction
    neg = sv[15];
    mag = 17'(neg ? 17'h0 - {sv[15], sv} : {sv[15], sv});
    case (num_i)
      panel_pkg::MN_MODE: mag = 17'(mon_i.mode);
      panel_pkg::MN_VER: mag = 17'(mon_i.version);
      panel_pkg::MN_POS_LO, panel_pkg::MN_POS_HI, panel_pkg::MN_CMD_LO, panel_pkg::MN_CMD_HI:
      begin
        neg = pv[31];
        mag = 17'(num_i[0] ? pm / panel_pkg::POS_SPLIT : pm % panel_pkg::POS_SPLIT);
      end
      panel_pkg::MN_ROTOR: mag = 17'(mon_i.rotor % panel_pkg::ROT_CYCLE);
      panel_pkg::MN_MODEL: mag = 17'(mon_i.model_num);
      panel_pkg::MN_FAULT: mag = 17'(mon_i.fault_code);
      default: ;
    endcase
    if (num_i != panel_pkg::MN_SPEED && num_i != panel_pkg::MN_TORQUE
        && num_i != panel_pkg::MN_FREQ && num_i[4:2] != 3'h1)
      neg = 1'b0;
    n.disp.dot = '0;
    n.disp.ch = panel_pkg::dec5(mag);
    if (neg)
      n.disp.ch[4] = panel_pkg::CH_MINUS;
    case (num_i)
      panel_pkg::MN_VER:
      begin
        n.disp.ch[4] = panel_pkg::CH_BLANK;
        n.disp.ch[3] = panel_pkg::CH_V;
      end
      panel_pkg::MN_MODEL:
      begin
        n.disp.ch[4:3] = {panel_pkg::CH_BLANK, panel_pkg::CH_BLANK};
        n.disp.ch[2] = mon_i.model_e ? panel_pkg::CH_E : panel_pkg::CH_S;
        if (mag < 17'h0000A)
          n.disp.ch[2:1] = {panel_pkg::CH_BLANK, n.disp.ch[2]};
      end
      panel_pkg::MN_FAULT:
      begin
        n.disp.ch[4:3] = {panel_pkg::CH_E, panel_pkg::CH_R};
        if (!mon_i.fault_act)
        begin
          n.disp.ch[2:0] = {3{panel_pkg::CH_BLANK}};
          n.disp.dot[3] = 1'b1;
        end
      end
      panel_pkg::MN_IN_HI, panel_pkg::MN_IN_LO, panel_pkg::MN_OUT:
      begin
        n.disp.ch = {5{panel_pkg::CH_BLANK}};
        for (int i = 0; i < 4; i++)
        begin
          if (num_i == panel_pkg::MN_IN_HI && i < 3)
            n.disp.ch[i] = mon_i.din_cur[i + 4] ? panel_pkg::CH_0 : panel_pkg::CH_1;
          if (num_i == panel_pkg::MN_IN_LO)
            n.disp.ch[i] = mon_i.din_cur[i] ? panel_pkg::CH_0 : panel_pkg::CH_1;
          if (num_i == panel_pkg::MN_OUT)
            n.disp.ch[i] = mon_i.dout_on[i] ? panel_pkg::CH_1 : panel_pkg::CH_0;
        end
      end
      default: ;
    endcase
  end

  // output register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= n;
  end

  assign disp_o = s.disp;
endmodule : mon_fmt

// *** verilog/panel_ctrl.sv ***
// Functional notes
// - at group level up and down step through groups zero to seven
// - until the unlock value 356 is saved, other parameters refuse edits
// - immediate parameters apply on save, deferred ones at next restart
// - set at group level enters numbers; up and down pick a number
// - value entry flashes the lowest digit; shift, or set before any change, moves it left
// - up and down change the flashing digit; save writes EEPROM, and RAM unless a deferred item is saved during a restart copy
// - escape returns to the previous menu level
// - monitored values at value level ignore editing keys
// - position splits into high times 10000 plus low, clipped to 999999999
// - position values shown are already gear-scaled system units
// - control mode codes zero to six as listed
// - pulse frequency shown unscaled in 0.1 kHz, signed by direction
// - rotor angle wraps over 0 to 9999
// - fault item shows a no-fault sign or a fault identifier
// - seven inputs shown as groups of three and four, 1 means no current
// - four outputs shown high to low, 1 means conducting
// - torque shown as percent of rated torque
// - software version shown as V and three digits
// - motor model shown as S or E and one or two digits
// - init command 1 restores defaults with start and done messages
// - init command 2 saves all working values with start and done messages
// - panel has five digits and five keys
// - holding up or down repeats the step
module panel_ctrl #(
  parameter int TICK_CYC = panel_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // keypad, high while pressed
  input wire logic [panel_pkg::NKEY-1:0] key_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // drive state values
  input wire panel_pkg::mon_t mon_i,
  // active parameter read port
  input wire logic [7:0] act_addr_i,
  output logic [16:0] act_data_o,
  // eeprom write channel
  output logic ee_valid_o,
  input wire logic ee_ready_i,
  output logic [7:0] ee_addr_o,
  output logic [16:0] ee_data_o,
  // led display
  output panel_pkg::disp_t disp_o
);
  localparam int TW = $clog2(TICK_CYC + 1);

  if (TICK_CYC < 2)
    $error("panel_ctrl: TICK_CYC too small");

  typedef enum logic [1:0] {L_GROUP, L_NUMBER, L_VALUE, L_EXEC} lvl_t;

  typedef struct packed {
    lvl_t lvl;
    logic [2:0] grp;
    logic [4:0] num;
    logic [16:0] val;
    logic [2:0] fpos;
    logic dirty;
    logic fl_en;
    logic fl_on;
    logic [7:0] fcnt;
    logic [TW-1:0] tcnt;
    logic tick;
    logic unlocked;
    logic ex_busy;
    logic ex_rst;
    logic [7:0] ex_idx;
    logic cp_busy;
    logic ld;
    logic [7:0] cp_idx;
    logic ee_v;
    logic [7:0] ee_a;
    logic [16:0] ee_d;
    logic ack;
    logic [31:0] rd;
    logic [7:0] paddr;
    logic [16:0] act_rd;
    panel_pkg::disp_t disp;
  } st_t;

  localparam st_t ST_RST = '{lvl: L_GROUP, cp_busy: 1'b1, ld: 1'b1, default: '0};

  st_t s;
  st_t n;
  logic [16:0] ram [256];
  logic [16:0] act [256];
  logic [panel_pkg::NKEY-1:0] kp;
  logic esc;
  logic up;
  logic dn;
  logic sh;
  logic set;
  logic edit_ok;
  logic is_init;
  logic is_mon;
  logic save;
  logic [16:0] step;
  logic [17:0] sum;
  logic ram_we;
  logic [7:0] ram_wa;
  logic [16:0] ram_wd;
  logic act_we;
  logic [7:0] act_wa;
  logic [16:0] act_wd;
  panel_pkg::dig5_t dig;
  panel_pkg::dig5_t nd;
  panel_pkg::disp_t fmt;

  // key conditioning on the millisecond tick
  key_cond #(
    .N(panel_pkg::NKEY)
  ) u_keys (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(s.tick),
    .key_i(key_i),
    .press_o(kp)
  );

  // monitored quantity layout
  mon_fmt u_fmt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .num_i(s.num),
    .mon_i(mon_i),
    .disp_o(fmt)
  );

  // one action per cycle, escape first
  assign esc = kp[panel_pkg::K_ESC] && !s.ld;
  assign up = kp[panel_pkg::K_UP] && !s.ld && !esc;
  assign dn = kp[panel_pkg::K_DN] && !s.ld && !esc && !up;
  assign sh = kp[panel_pkg::K_SH] && !s.ld && !esc && !up && !dn;
  assign set = kp[panel_pkg::K_SET] && !s.ld && !esc && !up && !dn && !sh;

  // selection qualifiers
  assign edit_ok = s.unlocked || (s.grp == panel_pkg::GRP_SYS && s.num == panel_pkg::NUM_UNLOCK);
  assign is_init = s.grp == panel_pkg::GRP_SYS && s.num == panel_pkg::NUM_INIT;
  assign is_mon = s.grp == panel_pkg::GRP_MON;

  // weight of the flashing digit
  always_comb
  begin
    case (s.fpos)
      3'h0: step = 17'h00001;
      3'h1: step = 17'h0000A;
      3'h2: step = 17'h00064;
      3'h3: step = 17'h003E8;
      default: step = 17'h02710;
    endcase
  end

  // next state
  always_comb
  begin
    n = s;
    save = 1'b0;
    ram_we = 1'b0;
    ram_wa = {s.grp, s.num};
    ram_wd = s.val;
    act_we = 1'b0;
    act_wa = {s.grp, s.num};
    act_wd = s.val;
    sum = {1'b0, s.val} + {1'b0, step};
    dig = panel_pkg::dec5(s.val);
    nd = panel_pkg::dec5({12'h000, s.num});

    // millisecond enable and flash phase
    n.tick = 1'b0;
    n.tcnt = s.tcnt + TW'(1);
    if (s.tcnt == TW'(TICK_CYC - 1))
    begin
      n.tcnt = '0;
      n.tick = 1'b1;
    end
    if (s.tick)
    begin
      n.fcnt = s.fcnt + 8'h01;
      if (s.fcnt == 8'(panel_pkg::FLASH_MS - 1))
      begin
        n.fcnt = '0;
        n.fl_on = !s.fl_on;
      end
    end

    // eeprom word taken
    if (s.ee_v && ee_ready_i)
      n.ee_v = 1'b0;

    // restore or save-all walk, one word per free channel slot
    if (s.ex_busy && !s.ee_v)
    begin
      n.ee_v = 1'b1;
      n.ee_a = s.ex_idx;
      n.ee_d = s.ex_rst ? panel_pkg::DEF_VAL : ram[s.ex_idx];
      if (s.ex_rst)
      begin
        ram_we = 1'b1; // defaults into working RAM
        ram_wa = s.ex_idx;
        ram_wd = panel_pkg::DEF_VAL;
      end
      n.ex_idx = s.ex_idx + 8'h01;
      if (s.ex_idx == panel_pkg::IDX_LAST)
        n.ex_busy = 1'b0;
    end

    // menu walk
    case (s.lvl)
      L_GROUP:
      begin
        if (up)
          n.grp = s.grp + 3'h1;
        else if (dn)
          n.grp = s.grp - 3'h1;
        else if (set)
        begin
          n.lvl = L_NUMBER;
          n.num = '0;
        end
      end
      L_NUMBER:
      begin
        if (esc)
          n.lvl = L_GROUP;
        else if (up)
          n.num = s.num + 5'h01;
        else if (dn)
          n.num = s.num - 5'h01;
        else if (set)
        begin
          n.lvl = L_VALUE;
          n.val = ram[{s.grp, s.num}];
          n.fpos = '0;
          n.dirty = 1'b0;
          n.fl_en = !is_mon;
        end
      end
      L_VALUE:
      begin
        if (esc)
        begin
          n.lvl = L_NUMBER;
          n.fl_en = 1'b0;
        end
        else if (is_mon)
          n.fl_en = 1'b0; // read-only item
        else if ((up || dn) && edit_ok)
        begin
          n.dirty = 1'b1;
          n.fl_en = 1'b1;
          if (up)
            n.val = sum > {1'b0, panel_pkg::VAL_MAX} ? panel_pkg::VAL_MAX : sum[16:0];
          else
            n.val = s.val < step ? panel_pkg::DEF_VAL : s.val - step;
        end
        else if (sh || (set && !s.dirty))
        begin
          n.fl_en = 1'b1;
          n.fpos = s.fpos == panel_pkg::FPOS_LAST ? 3'h0 : s.fpos + 3'h1;
        end
        else if (set && !s.ee_v && !s.ex_busy && edit_ok)
        begin
          n.dirty = 1'b0;
          n.fl_en = 1'b0;
          if (is_init && (s.val == panel_pkg::INIT_RESTORE || s.val == panel_pkg::INIT_SAVE))
          begin
            n.lvl = L_EXEC;
            n.ex_busy = 1'b1;
            n.ex_rst = s.val == panel_pkg::INIT_RESTORE;
            n.ex_idx = '0;
          end
          else
          begin
            save = 1'b1;
            ram_we = 1'b1;
            n.ee_v = 1'b1;
            n.ee_a = {s.grp, s.num};
            n.ee_d = s.val;
            act_we = panel_pkg::IMM_GROUPS[s.grp];
            if (s.grp == panel_pkg::GRP_SYS && s.num == panel_pkg::NUM_UNLOCK
                && s.val == panel_pkg::UNLOCK_VAL)
              n.unlocked = 1'b1;
          end
        end
      end
      L_EXEC:
      begin
        if (esc)
          n.lvl = L_NUMBER;
      end
      default: n.lvl = L_GROUP;
    endcase

    // restart copy of working values into the active set
    if (s.cp_busy && !act_we && !(s.ld && ram_we))
    begin
      act_we = 1'b1; // deferred values take effect here
      act_wa = s.cp_idx;
      act_wd = s.ld ? panel_pkg::DEF_VAL : ram[s.cp_idx];
      ram_we = s.ld;
      ram_wa = s.cp_idx;
      ram_wd = panel_pkg::DEF_VAL;
      n.cp_idx = s.cp_idx + 8'h01;
      if (s.cp_idx == panel_pkg::IDX_LAST)
      begin
        n.cp_busy = 1'b0;
        n.ld = 1'b0;
      end
    end

    // wishbone: ack one cycle after the strobe, write on that edge
    n.ack = wb_cyc_i && wb_stb_i && !s.ack;
    if (n.ack)
    begin
      case (wb_adr_i)
        panel_pkg::WB_CTRL: n.rd = {31'h00000000, s.cp_busy};
        panel_pkg::WB_STAT: n.rd = {18'h00000, s.lvl, s.unlocked, s.ex_busy, s.cp_busy,
                                   s.fl_en, s.grp, s.num};
        panel_pkg::WB_PADDR: n.rd = {24'h000000, s.paddr};
        panel_pkg::WB_PDATA: n.rd = {15'h0000, ram[s.paddr]};
        default: n.rd = '0;
      endcase
      if (wb_we_i && wb_sel_i[0] && wb_adr_i == panel_pkg::WB_CTRL && wb_dat_i[0] && !s.cp_busy)
      begin
        n.cp_busy = 1'b1; // restart request
        n.cp_idx = '0;
      end
      if (wb_we_i && wb_sel_i[0] && wb_adr_i == panel_pkg::WB_PADDR)
        n.paddr = wb_dat_i[7:0];
    end
    n.act_rd = act[act_addr_i];

    // five-digit display image
    n.disp.dot = '0;
    n.disp.ch = {5{panel_pkg::CH_BLANK}};
    case (s.lvl)
      L_GROUP:
      begin
        n.disp.ch[4:3] = {panel_pkg::CH_P, panel_pkg::CH_0};
        n.disp.ch[2] = {2'h0, s.grp};
      end
      L_NUMBER:
      begin
        n.disp.ch[4:3] = {panel_pkg::CH_P, panel_pkg::CH_0};
        n.disp.ch[2] = {2'h0, s.grp};
        n.disp.dot[2] = 1'b1;
        n.disp.ch[1:0] = nd[1:0];
      end
      L_VALUE:
      begin
        if (is_mon)
          n.disp = fmt;
        else
        begin
          n.disp.ch = dig;
          if (s.fl_en && s.fl_on)
            n.disp.ch[s.fpos] = panel_pkg::CH_BLANK;
        end
      end
      L_EXEC: n.disp.ch = s.ex_busy ? panel_pkg::MSG_START : panel_pkg::MSG_DONE;
      default: ;
    endcase
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= ST_RST;
    else
      s <= n;
  end

  // parameter stores, working and active
  always_ff @(posedge clk_i)
  begin
    if (ram_we)
      ram[ram_wa] <= ram_wd;
    if (act_we)
      act[act_wa] <= act_wd;
  end

  // outputs
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rd;
  assign act_data_o = s.act_rd;
  assign ee_valid_o = s.ee_v;
  assign ee_addr_o = s.ee_a;
  assign ee_data_o = s.ee_d;
  assign disp_o = s.disp;

  // checks
  property p_grp_wrap;
    @(posedge clk_i) disable iff (rst_i)
    s.lvl == L_GROUP && up && s.grp == 3'h7 |=> s.grp == 3'h0;
  endproperty
  a_grp_wrap: assert property (p_grp_wrap) else $error("group did not wrap");

  property p_lock;
    @(posedge clk_i) disable iff (rst_i)
    s.lvl == L_VALUE && !s.unlocked && !edit_ok && !s.ex_busy && !s.ld |-> !ram_we && !save;
  endproperty
  a_lock: assert property (p_lock) else $error("locked parameter written");

  property p_imm;
    @(posedge clk_i) disable iff (rst_i)
    save && panel_pkg::IMM_GROUPS[s.grp] |=> act[$past(ram_wa)] == $past(s.val);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate value not applied");

  property p_enter;
    @(posedge clk_i) disable iff (rst_i)
    s.lvl == L_NUMBER && set ##1 1'b1 |-> s.lvl == L_VALUE && s.fpos == 3'h0;
  endproperty
  a_enter: assert property (p_enter) else $error("value entry wrong");

  property p_save;
    @(posedge clk_i) disable iff (rst_i)
    save |=> s.ee_v && s.ee_d == $past(s.val) && !s.fl_en && ram[$past(ram_wa)] == s.ee_d;
  endproperty
  a_save: assert property (p_save) else $error("save incomplete");

  property p_esc;
    @(posedge clk_i) disable iff (rst_i)
    esc && (s.lvl == L_VALUE || s.lvl == L_EXEC) |=> s.lvl == L_NUMBER;
  endproperty
  a_esc: assert property (p_esc) else $error("escape did not go up");

  property p_ro;
    @(posedge clk_i) disable iff (rst_i)
    s.lvl == L_VALUE && is_mon && !esc |=> $stable(s.val) && s.lvl == L_VALUE && !s.dirty;
  endproperty
  a_ro: assert property (p_ro) else $error("monitor value edited");

  property p_done;
    @(posedge clk_i) disable iff (rst_i)
    s.lvl == L_EXEC && !s.ex_busy ##1 s.lvl == L_EXEC |-> s.disp.ch == panel_pkg::MSG_DONE;
  endproperty
  a_done: assert property (p_done) else $error("done message missing");
endmodule : panel_ctrl

// *** sim/panel_operator.sv ***
module panel_operator (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // press request from the bench
  input wire logic go_i,
  input wire logic [2:0] sel_i,
  // keypad and eeprom sink
  output logic [4:0] key_o,
  output logic ee_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cnt_q;
  // one press: key held 300 cycles, then released 300 cycles
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= 10'h000;
    else if (go_i)
      cnt_q <= 10'h258;
    else if (cnt_q != 10'h000)
      cnt_q <= cnt_q - 10'h001;
  end
  // one of the five keys, long enough to pass the debounce
  assign key_o = (cnt_q > 10'h12C) ? (5'h01 << sel_i) : 5'h00;
  // sink stalls four cycles in eight while a press runs, ready when idle
  assign ee_ready_o = !cnt_q[2];
endmodule : panel_operator

// *** sim/keypad_menu_monitor_display_bench.sv ***
module keypad_menu_monitor_display_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, go, we, cyc, ee_valid, ee_ready, ack;
  logic [2:0] sel;
  logic [4:0] key;
  logic [7:0] adr, act_addr;
  logic [31:0] wdat, rdat;
  logic [16:0] act_data;
  logic [63:0] exp_q[$];
  int errors, checked, n;
  int cyc_n = 0;
  panel_pkg::mon_t mon;
  panel_pkg::disp_t disp;
  panel_operator op (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .sel_i(sel), .key_o(key),
    .ee_ready_o(ee_ready));
  panel_ctrl #(.TICK_CYC(20)) DUT (.clk_i(clk_i), .rst_i(rst_i), .key_i(key), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .mon_i(mon), .act_addr_i(act_addr),
    .act_data_o(act_data), .ee_valid_o(ee_valid), .ee_ready_i(ee_ready), .ee_addr_o(),
    .ee_data_o(), .disp_o(disp));
  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // one comparison, counted
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic results;
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  // one key press through the operator model
  task automatic press(input int k);
    go <= 1'b1;
    sel <= 3'(k);
    @(posedge clk_i);
    go <= 1'b0;
    repeat (600) @(posedge clk_i);
  endtask : press
  // classic wishbone cycle; the expected read word is noted for the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, m, e);
    exp_q.push_back({m, e});
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  // monitor: oldest note against each acknowledged word
  always @(posedge clk_i)
  begin
    logic [63:0] t;
    if (ack === 1'b1)
    begin
      t = exp_q.pop_front();
      check("wb_dat_o", t[31:0], rdat & t[63:32]);
    end
  end
  // hang guard
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 80000)
    begin
      errors++;
      results();
    end
  end
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    {go, we, cyc, sel, adr, wdat, act_addr, mon} = '0;
    errors = 0;
    checked = 0;
    void'($urandom(32'hE1E8AA2A));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    mon <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    repeat (300) @(posedge clk_i);
    bus(0, 8'h10, 32'h0, 32'hFFFFFFFF, 32'h0);
    bus(0, 8'h04, 32'h0, 32'h000038FF, 32'h0);
    n = $urandom_range(7, 1);
    repeat (n + 8) press(panel_pkg::K_UP);
    bus(0, 8'h04, 32'h0, 32'h000038FF, 32'(n << 5));
    repeat (n + 1) press(panel_pkg::K_DN);
    bus(0, 8'h04, 32'h0, 32'h000038FF, 32'h000000E0);
    repeat (2) press(panel_pkg::K_UP);
    press(panel_pkg::K_SET);
    press(panel_pkg::K_SET);
    bus(0, 8'h04, 32'h0, 32'h000038FF, 32'h00002020);
    press(panel_pkg::K_UP);
    press(panel_pkg::K_SET);
    bus(1, 8'h08, 32'h20, 32'h0, 32'h0);
    bus(0, 8'h0C, 32'h0, 32'h0001FFFF, 32'h0);
    press(panel_pkg::K_ESC);
    bus(0, 8'h04, 32'h0, 32'h000038FF, 32'h00001020);
    press(panel_pkg::K_ESC);
    press(panel_pkg::K_DN);
    press(panel_pkg::K_SET);
    press(panel_pkg::K_SET);
    // unlock value entered digit by digit
    repeat (6) press(panel_pkg::K_UP);
    press(panel_pkg::K_SH);
    repeat (5) press(panel_pkg::K_UP);
    press(panel_pkg::K_SH);
    repeat (3) press(panel_pkg::K_UP);
    press(panel_pkg::K_SET);
    bus(0, 8'h04, 32'h0, 32'h00000800, 32'h00000800);
    press(panel_pkg::K_ESC);
    press(panel_pkg::K_ESC);
    press(panel_pkg::K_UP);
    press(panel_pkg::K_SET);
    press(panel_pkg::K_SET);
    press(panel_pkg::K_UP);
    press(panel_pkg::K_SET);
    bus(0, 8'h0C, 32'h0, 32'h0001FFFF, 32'h1);
    act_addr <= 8'h20;
    repeat (3) @(posedge clk_i);
    check("act_data_o", 32'h1, 32'(act_data));
    act_addr <= 8'h00;
    repeat (3) @(posedge clk_i);
    check("act_data_o", 32'h0, 32'(act_data));
    bus(1, 8'h00, 32'h1, 32'h0, 32'h0);
    repeat (300) @(posedge clk_i);
    check("act_data_o", 32'h164, 32'(act_data));
    bus(1, 8'h08, 32'h0, 32'h0, 32'h0);
    bus(0, 8'h0C, 32'h0, 32'h0001FFFF, 32'h164);
    // monitored control mode: up key ignored, digits laid out
    repeat (2) press(panel_pkg::K_ESC);
    press(panel_pkg::K_UP);
    press(panel_pkg::K_SET);
    press(panel_pkg::K_UP);
    press(panel_pkg::K_SET);
    press(panel_pkg::K_UP);
    bus(0, 8'h04, 32'h0, 32'h000039FF, 32'h00002841);
    check("disp_o", 32'({20'h00000, 5'(mon.mode), 5'h00}), 32'(disp));
    // save-all command through the init parameter
    repeat (2) press(panel_pkg::K_ESC);
    repeat (2) press(panel_pkg::K_DN);
    press(panel_pkg::K_SET);
    repeat (16) press(panel_pkg::K_UP);
    press(panel_pkg::K_SET);
    repeat (2) press(panel_pkg::K_UP);
    press(panel_pkg::K_SET);
    repeat (1000) @(posedge clk_i);
    bus(0, 8'h04, 32'h0, 32'h00003C00, 32'h00003800);
    check("disp_o", 32'({panel_pkg::MSG_DONE, 5'h00}), 32'(disp));
    results();
  end
endmodule : keypad_menu_monitor_display_bench
